/* dv/cst_torque_arrival_status_bench.sv */
// self-checking bench for the torque arrival status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module cst_torque_arrival_status_bench
  import torque_status_pkg::*;
;
  // ==========================================================
  // stimulus and design
  logic               ref_clk_i = 1'b0;
  logic               reset_n_i = 1'b0;
  obj_req_t           req_i;
  logic [31:0]        rdata_o, e;
  logic               rvalid_o, pos_cmd_flush_o, torque_reached_output;
  drive_meas_t        meas_i = '{mode: MODE_CST, default: '0};
  logic signed [31:0] speed_demand_i = '0;
  logic signed [31:0] speed_limited_o;
  logic               pos_cmd_pending_i = 1'b0;
  logic [15:0]        status_word_o, control_word_o;
  logic [31:0]        exp_q[$];
  logic [31:0]        seed = 32'h0001_0b3e;
  int                 err_count = 0, num_checks = 0, cyc = 0, flushes = 0;
  localparam logic [15:0] TQ [8] = '{16'h0514, 16'h047e, 16'h04b0, 16'h044c,
                                     16'h044b, 16'h047e, 16'h04b1, 16'hfe0c};
  localparam logic [7:0]  AR = 8'b0100_1111;
  cst_torque_arrival_status i_dut (.*);
  fieldbus_master_model i_mst (.ref_clk_i(ref_clk_i), .req_o(req_i));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] x);
    exp_q.push_back(x);
    i_mst.xfer(1'b0, ix, sb, 32'h0000_0000);
  endtask
  // random status inputs, then the status word is read back
  task automatic step(input logic [15:0] tq, input logic ar);
    seed = xs(seed);
    @(posedge ref_clk_i);
    meas_i.torque      <= tq;
    meas_i.following   <= seed[0];
    meas_i.homing_done <= seed[1];
    meas_i.velocity    <= seed;
    pos_cmd_pending_i  <= seed[2];
    speed_demand_i     <= seed;
    repeat (4) @(posedge ref_clk_i);
    `CHK("torque reached", ar, torque_reached_output)
    rd(IDX_STATUS_WORD, 8'h00, {16'h0000, seed[1], 2'b00, seed[0], 1'b0, ar, 10'h000});
  endtask
  task automatic spd(input logic [31:0] ce, input logic [31:0] sd, input logic [31:0] x);
    i_mst.xfer(1'b1, IDX_SPEED_CEILING, 8'h00, ce);
    @(posedge ref_clk_i) speed_demand_i <= sd;
    repeat (3) @(posedge ref_clk_i);
    `CHK("clamped speed", x, speed_limited_o)
  endtask
  // read answers and the hang limit
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (pos_cmd_flush_o === 1'b1) flushes <= flushes + 1;
    if (rvalid_o === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 32'hdead_beef;
      `CHK("read data", e, rdata_o)
    end
    if (cyc == 4000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd(IDX_STATUS_WORD, 8'h00, 32'h0000_0000);
    rd(IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_SET, 32'h0000_0000);
    rd(IDX_SPEED_CEILING, 8'h00, CEILING_RESET);
    rd(16'h1234, 8'h00, 32'h0000_0000);
    $display("test reset values done");
    i_mst.xfer(1'b1, IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_REF, 32'h0000_03e8);
    i_mst.xfer(1'b1, IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_SET, 32'h0000_00c8);
    i_mst.xfer(1'b1, IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_CLR, 32'h0000_0064);
    for (int k = 0; k < 8; k++) step(TQ[k], AR[k]);
    $display("test hysteresis done");
    i_mst.xfer(1'b1, IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_SET, 32'h0000_ffff);
    rd(IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_SET, 32'h0000_0bb8);
    rd(IDX_TORQUE_ARRIVAL, SUB_ARRIVAL_REF, 32'h0000_03e8);
    i_mst.xfer(1'b1, IDX_STATUS_WORD, 8'h00, 32'h0000_ffff);
    i_mst.xfer(1'b1, IDX_CONTROL_WORD, 8'h00, 32'h0000_a5c3);
    rd(IDX_CONTROL_WORD, 8'h00, 32'h0000_a5c3);
    step(16'h0000, 1'b0);
    rd(IDX_MEAS_VELOCITY, 8'h00, seed);
    rd(IDX_MODE_READBACK, 8'h00, {24'h00_0000, MODE_CST});
    rd(IDX_MEAS_TORQUE, 8'h00, 32'h0000_0000);
    `CHK("control word", 16'ha5c3, control_word_o)
    $display("test objects done");
    spd(32'h0000_03e8, 32'h8000_0000, 32'hffff_fc18);
    spd(32'h0001_0000, 32'h7fff_ffff, 32'h0000_1770);
    spd(32'h0001_0000, 32'h0000_0123, 32'h0000_0123);
    $display("test speed clamp done");
    @(posedge ref_clk_i) meas_i.mode <= MODE_PROFILE_POS;
    step(16'h0000, 1'b0);
    @(posedge ref_clk_i) meas_i.mode <= MODE_CST;
    step(16'h0000, 1'b0);
    `CHK("flush pulses", 1, flushes)
    $display("test mode exit done");
    print_verdict();
  end
endmodule

/* dv/cst_torque_arrival_status_monitor.sv */
// checker: arrival hysteresis, status bits, speed clamp and flush
`timescale 1ns/1ps
module cst_torque_arrival_status_monitor
  import torque_status_pkg::*;
#(
  parameter logic [31:0] RATED_MAX_SPEED = 32'h0000_1770
) (
  // watched ports
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  input  wire obj_req_t           req_i,
  input  wire logic [31:0]        rdata_o,
  input  wire logic               rvalid_o,
  input  wire drive_meas_t        meas_i,
  input  wire logic signed [31:0] speed_demand_i,
  input  wire logic               pos_cmd_pending_i,
  input  wire logic               pos_cmd_flush_o,
  input  wire logic               torque_reached_output,
  input  wire logic signed [31:0] speed_limited_o,
  input  wire logic [15:0]        status_word_o,
  input  wire logic [15:0]        control_word_o
);
  // ==========================================================
  // shadow objects, tracked from writes
  logic [15:0]        ref_s, set_s, clr_s, wv;
  logic [31:0]        ceil_s;
  logic signed [32:0] diff, sd, lm;
  logic signed [31:0] sp;
  logic               hit, set_c, clr_c;
  assign hit = req_i.wr && req_i.index == IDX_TORQUE_ARRIVAL;
  assign wv = (req_i.wdata > 32'(THRESH_MAX)) ? THRESH_MAX : req_i.wdata[15:0];
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_s  <= THRESH_RESET;
      set_s  <= THRESH_RESET;
      clr_s  <= THRESH_RESET;
      ceil_s <= CEILING_RESET;
    end else begin
      if (hit && req_i.sub == SUB_ARRIVAL_REF) ref_s <= wv;
      if (hit && req_i.sub == SUB_ARRIVAL_SET) set_s <= wv;
      if (hit && req_i.sub == SUB_ARRIVAL_CLR) clr_s <= wv;
      if (req_i.wr && req_i.index == IDX_SPEED_CEILING) ceil_s <= req_i.wdata;
    end
  end
  // signed difference, so torque below the reference clears
  assign diff = 33'(meas_i.torque) - 33'(ref_s);
  assign set_c = diff > $signed(33'(set_s));
  assign clr_c = !set_c && diff < $signed(33'(clr_s));
  assign sd = 33'(speed_demand_i);
  assign lm = 33'((ceil_s < RATED_MAX_SPEED) ? ceil_s : RATED_MAX_SPEED);
  assign sp = 32'((meas_i.mode != MODE_CST) ? sd : (sd > lm) ? lm : (sd < -lm) ? -lm : sd);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_arrival_set: assert property (set_c |-> ##2 torque_reached_output && status_word_o[10])
    else $error("torque reached not raised");
  a_arrival_clear: assert property (clr_c |-> ##2 !torque_reached_output && !status_word_o[10])
    else $error("torque reached not cleared");
  a_arrival_hold: assert property (!set_c && !clr_c |-> ##2 $stable(torque_reached_output))
    else $error("torque reached moved inside band");
  a_follow_bit: assert property ($past(reset_n_i) |-> status_word_o[12] == $past(meas_i.following))
    else $error("following bit wrong");
  a_homing_bit: assert property ($past(reset_n_i) |-> status_word_o[15] == $past(meas_i.homing_done))
    else $error("homing bit wrong");
  a_thr_saturate: assert property (rvalid_o && $past(req_i.index) == IDX_TORQUE_ARRIVAL |-> rdata_o <= 32'(THRESH_MAX))
    else $error("arrival object above range");
  a_speed_clamp: assert property ($past(reset_n_i) |-> speed_limited_o == $past(sp))
    else $error("speed clamp wrong");
  a_pp_flush: assert property ($past(reset_n_i) && $past(meas_i.mode) == MODE_PROFILE_POS && meas_i.mode != MODE_PROFILE_POS |-> ##1 pos_cmd_flush_o)
    else $error("no flush on leaving profile position");
  c_arrive: cover property ($rose(torque_reached_output));
  c_flush: cover property (pos_cmd_flush_o);
  c_clamp: cover property (meas_i.mode == MODE_CST && speed_limited_o != speed_demand_i);
endmodule

bind cst_torque_arrival_status cst_torque_arrival_status_monitor #(.RATED_MAX_SPEED(RATED_MAX_SPEED)) i_mon (.*);

/* dv/fieldbus_master_model.sv */
// master model: object writes and reads over cyclic process data
`timescale 1ns/1ps
module fieldbus_master_model
  import torque_status_pkg::*;
#(
  parameter int LOOP_TICKS = 2
) (
  // clock and request
  input  wire logic ref_clk_i,
  output obj_req_t  req_o
);
  // ==========================================================
  // cycle scaled down, the real loop period is far too long to run
  localparam int CYCLE_TICKS = 4 * LOOP_TICKS;
  obj_req_t r;
  initial req_o = '0;
  // master supplies the setpoint objects, the drive plans itself
  task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                      input logic [31:0] d);
    r = {w, !w, ix, sb, d};
    @(posedge ref_clk_i);
    req_o <= r;
    @(posedge ref_clk_i);
    req_o <= {2'b00, ~r[55:0]};
    repeat (CYCLE_TICKS - 2) @(posedge ref_clk_i);
  endtask
endmodule

/* verilog/cst_torque_arrival_status.sv */
// top: torque arrival status, speed clamp and profile-position exit logic
`timescale 1ns/1ps

module cst_torque_arrival_status
  import torque_status_pkg::*;
#(
  parameter logic [31:0] RATED_MAX_SPEED = 32'h0000_1770
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  // object access from the process data
  input  wire obj_req_t            req_i,
  output logic [31:0]              rdata_o,
  output logic                     rvalid_o,
  // drive measurements
  input  wire drive_meas_t         meas_i,
  input  wire logic signed [31:0]  speed_demand_i,
  // profile position command queue state
  input  wire logic                pos_cmd_pending_i,
  output logic                     pos_cmd_flush_o,
  // results
  output logic                     torque_reached_output,
  output logic signed [31:0]       speed_limited_o,
  output logic [15:0]              status_word_o,
  output logic [15:0]              control_word_o
);

  // ==========================================================
  // writable objects
  logic [15:0] arrival_ref_reg;
  logic [15:0] arrival_set_reg;
  logic [15:0] arrival_clr_reg;
  logic [15:0] control_reg;
  logic [31:0] ceiling_reg;

  // values beyond 3000 saturate rather than being dropped
  function automatic logic [15:0] clip_thr(input logic [31:0] v);
    clip_thr = (v > {16'h0000, THRESH_MAX}) ? THRESH_MAX : v[15:0];
  endfunction

  logic wr_arrival;
  assign wr_arrival = req_i.wr && (req_i.index == IDX_TORQUE_ARRIVAL);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arrival_ref_reg <= THRESH_RESET;
      arrival_set_reg <= THRESH_RESET;
      arrival_clr_reg <= THRESH_RESET;
    end else if (wr_arrival) begin
      if (req_i.sub == SUB_ARRIVAL_REF) begin
        arrival_ref_reg <= clip_thr(req_i.wdata);
      end
      if (req_i.sub == SUB_ARRIVAL_SET) begin
        arrival_set_reg <= clip_thr(req_i.wdata);
      end
      if (req_i.sub == SUB_ARRIVAL_CLR) begin
        arrival_clr_reg <= clip_thr(req_i.wdata);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_reg <= 16'h0000;
      ceiling_reg <= CEILING_RESET;
    end else if (req_i.wr) begin
      if (req_i.index == IDX_CONTROL_WORD) begin
        control_reg <= req_i.wdata[15:0];
      end
      if (req_i.index == IDX_SPEED_CEILING) begin
        ceiling_reg <= req_i.wdata;
      end
    end
  end

  // ==========================================================
  // torque arrival comparison
  logic reached;

  torque_arrival_cmp #(
    .W (16)
  ) u_cmp (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .torque_i    (meas_i.torque),
    .reference_i (arrival_ref_reg),
    .set_thr_i   (arrival_set_reg),
    .clr_thr_i   (arrival_clr_reg),
    .reached_o   (reached)
  );

  // ==========================================================
  // status word
  logic [15:0] status_next;

  always_comb begin
    status_next = STATUS_RESET;
    status_next[STAT_BIT_TORQUE_ARRIVED] = reached;
    status_next[STAT_BIT_FOLLOWING]      = meas_i.following;
    status_next[STAT_BIT_HOMING_DONE]    = meas_i.homing_done;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_word_o         <= STATUS_RESET;
      torque_reached_output <= 1'b0;
    end else begin
      status_word_o         <= status_next;
      torque_reached_output <= reached;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_word_o <= 16'h0000;
    end else begin
      control_word_o <= control_reg;
    end
  end

  // ==========================================================
  // speed clamp, symmetric about zero
  logic [31:0]        limit;
  logic signed [32:0] lim_s;
  logic signed [32:0] dem_s;

  assign limit = (ceiling_reg < RATED_MAX_SPEED) ? ceiling_reg : RATED_MAX_SPEED;
  assign lim_s = $signed({1'b0, limit});
  assign dem_s = $signed({speed_demand_i[31], speed_demand_i});

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_limited_o <= 32'sh0000_0000;
    end else if (meas_i.mode != MODE_CST) begin
      speed_limited_o <= speed_demand_i;
    end else if (dem_s > lim_s) begin
      speed_limited_o <= lim_s[31:0];
    end else if (dem_s < -lim_s) begin
      speed_limited_o <= 32'(-lim_s);
    end else begin
      speed_limited_o <= speed_demand_i;
    end
  end

  // ==========================================================
  // profile position exit: the planner keeps the trajectory itself,
  // this block only tells it to discard queued targets
  logic [7:0] mode_prev_reg;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_prev_reg <= 8'h00;
    end else begin
      mode_prev_reg <= meas_i.mode;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_cmd_flush_o <= 1'b0;
    end else begin
      // pulse regardless of pending state, so nothing stale survives
      pos_cmd_flush_o <= (mode_prev_reg == MODE_PROFILE_POS) &&
                         (meas_i.mode != MODE_PROFILE_POS);
    end
  end

  // ==========================================================
  // read path, one cycle latency
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (req_i.index)
      IDX_TORQUE_ARRIVAL: begin
        if (req_i.sub == SUB_ARRIVAL_REF) rd_mux = {16'h0000, arrival_ref_reg};
        else if (req_i.sub == SUB_ARRIVAL_SET) rd_mux = {16'h0000, arrival_set_reg};
        else if (req_i.sub == SUB_ARRIVAL_CLR) rd_mux = {16'h0000, arrival_clr_reg};
      end
      IDX_FAULT_CODE:    rd_mux = {16'h0000, meas_i.fault};
      IDX_CONTROL_WORD:  rd_mux = {16'h0000, control_reg};
      IDX_STATUS_WORD:   rd_mux = {16'h0000, status_word_o};
      IDX_MODE_READBACK: rd_mux = {{24{meas_i.mode[7]}}, meas_i.mode};
      IDX_MEAS_VELOCITY: rd_mux = meas_i.velocity;
      IDX_TORQUE_DEMAND: rd_mux = {{16{meas_i.torque_demand[15]}}, meas_i.torque_demand};
      IDX_MEAS_TORQUE:   rd_mux = {{16{meas_i.torque[15]}}, meas_i.torque};
      IDX_SPEED_CEILING: rd_mux = ceiling_reg;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o  <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= req_i.rd ? rd_mux : 32'h0000_0000;
      rvalid_o <= req_i.rd;
    end
  end

endmodule

/* verilog/torque_arrival_cmp.sv */
// two-threshold torque arrival comparator with hysteresis
`timescale 1ns/1ps
module torque_arrival_cmp
  import torque_status_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  // operands
  input  wire logic signed [W-1:0] torque_i,
  input  wire logic        [W-1:0] reference_i,
  input  wire logic        [W-1:0] set_thr_i,
  input  wire logic        [W-1:0] clr_thr_i,
  // result
  output logic                     reached_o
);

  // ==========================================================
  // difference, one bit wider so it cannot wrap
  logic signed [W:0] diff;
  assign diff = $signed({torque_i[W-1], torque_i}) - $signed({1'b0, reference_i});

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reached_o <= 1'b0;
    end else if (diff > $signed({1'b0, set_thr_i})) begin
      reached_o <= 1'b1;
    end else if (diff < $signed({1'b0, clr_thr_i})) begin
      reached_o <= 1'b0;
    end
    // between the thresholds the flag holds
  end

endmodule

/* verilog/torque_status_pkg.sv */
// package: object indices, status bit positions, mode codes and limits
package torque_status_pkg;

  // ==========================================================
  // object dictionary indices and sub-indices
  localparam logic [15:0] IDX_TORQUE_ARRIVAL = 16'h2015;
  localparam logic [7:0]  SUB_ARRIVAL_REF    = 8'h11;
  localparam logic [7:0]  SUB_ARRIVAL_SET    = 8'h12;
  localparam logic [7:0]  SUB_ARRIVAL_CLR    = 8'h13;
  localparam logic [15:0] IDX_FAULT_CODE     = 16'h603f;
  localparam logic [15:0] IDX_CONTROL_WORD   = 16'h6040;
  localparam logic [15:0] IDX_STATUS_WORD    = 16'h6041;
  localparam logic [15:0] IDX_MODE_READBACK  = 16'h6061;
  localparam logic [15:0] IDX_MEAS_VELOCITY  = 16'h606c;
  localparam logic [15:0] IDX_TORQUE_DEMAND  = 16'h6074;
  localparam logic [15:0] IDX_MEAS_TORQUE    = 16'h6077;
  localparam logic [15:0] IDX_SPEED_CEILING  = 16'h607f;

  // ==========================================================
  // status word fields and reset values
  localparam int          STAT_BIT_TORQUE_ARRIVED = 10;
  localparam int          STAT_BIT_FOLLOWING      = 12;
  localparam int          STAT_BIT_HOMING_DONE    = 15;
  localparam logic [15:0] STATUS_RESET            = 16'h0000;
  localparam logic [15:0] THRESH_RESET            = 16'h0000;
  localparam logic [31:0] CEILING_RESET           = 32'hffff_ffff;
  localparam logic [15:0] THRESH_MAX              = 16'h0bb8; // 3000 x 0.1 %

  // ==========================================================
  // operating modes
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_CST         = 8'h0a;

  // ==========================================================
  // object access request carried from the process-data port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } obj_req_t;

  // live drive measurements feeding status objects
  typedef struct packed {
    logic signed [15:0] torque;
    logic signed [15:0] torque_demand;
    logic signed [31:0] velocity;
    logic        [15:0] fault;
    logic        [7:0]  mode;
    logic               following;
    logic               homing_done;
  } drive_meas_t;

endpackage
